// ---- rtl/psc_pkg.sv ----
// Purpose: Shared constants for the power management status and control block.
// Assumes: AXI4-Lite with 32-bit data and an 8-bit byte address.
// Notes: Field positions describe the 8-bit control register in the low lane.
package psc_pkg;

   // Bus geometry.
   localparam int PSC_ADDR_W = 8;
   localparam int PSC_DATA_W = 32;

   // Register byte offsets.
   localparam logic [7:0] PSC_OFF_CTRL = 8'h00;
   localparam logic [7:0] PSC_OFF_IRQ_STATUS = 8'h04;
   localparam logic [7:0] PSC_OFF_IRQ_MASK = 8'h08;

   // Field positions in the control register.
   localparam int PSC_BIT_WARN_FLAG = 7;
   localparam int PSC_BIT_WARN_ACK = 6;
   localparam int PSC_BIT_DETECT_TRIP = 5;
   localparam int PSC_BIT_WARN_TRIP = 4;
   localparam int PSC_BIT_PPD_FLAG = 3;
   localparam int PSC_BIT_PPD_ACK = 2;
   localparam int PSC_BIT_PD_ENABLE = 1;
   localparam int PSC_BIT_PD_TYPE = 0;

   // Interrupt event positions, shared by status and mask.
   localparam int PSC_IRQ_W = 2;
   localparam int PSC_IRQ_WARN = 0;
   localparam int PSC_IRQ_PPD_WAKE = 1;

   // Reset values.
   localparam logic [PSC_IRQ_W-1:0] PSC_IRQ_RESET = 2'h0;
   localparam logic PSC_BIT_RESET = 1'b0;

   // Response codes.
   localparam logic [1:0] PSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PSC_RESP_SLVERR = 2'h2;

endpackage : psc_pkg

// ---- rtl/psc_sync.sv ----
// Purpose: Two-stage synchroniser for levels arriving from outside sys_clk.
// Assumes: Inputs are slow levels; single-bit metastability only.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module psc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Asynchronous level in, synchronised level out.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Two flops in series; nothing else looks at the first one.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule : psc_sync

// ---- rtl/psc_sticky.sv ----
// Purpose: Bank of sticky flags with set taking priority over clear.
// Assumes: Set and clear are single-cycle terms on sys_clk.
// Notes: An event in the clearing cycle survives, so none is lost.
`timescale 1ns/100ps
module psc_sticky #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Set and clear terms.
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] clr_in,
   // Flag state and its next value.
   output logic [WIDTH-1:0] flag_out,
   output logic [WIDTH-1:0] nxt_flag_out
);

   logic [WIDTH-1:0] flag_ff;

   // Set wins over clear.
   assign nxt_flag_out = set_in | (flag_ff & ~clr_in);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         flag_ff <= '0;
      else
         flag_ff <= nxt_flag_out;
   end

   assign flag_out = flag_ff;

endmodule : psc_sticky

// ---- rtl/psc_top.sv ----
// Purpose: Power management status and control register with AXI4-Lite access.
// Assumes: The analog comparators sit outside; only their warning level enters.
// Notes: The reset controller reports on reset_is_por whether rst_n is a power-on reset.
// Functional notes
// - Warning flag sets whenever supply is below warning level, including right after reset.
// - Warning flag stays set once a warning has occurred until cleared.
// - Writing one to bit 6 clears warning flag only when warning is absent.
// - Bit 5 drives detect trip select; one means high trip point.
// - Bit 4 drives warning trip select; one means high trip point.
// - Power-on reset clears everything; other resets keep the two trip selects.
// - Partial power-down flag, bit 3, sets on wake from partial power-down stop.
// - Writing one to bit 2 clears the partial power-down flag.
// - Bit 1 is write-once and permits the deep power-down stop modes.
// - Bit 0 is write-once; zero full, one partial power-down stop.
`timescale 1ns/100ps
module psc_top (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reset_is_por,
   // Analog and power controller interface.
   input wire logic low_supply_warning,
   input wire logic wake_from_partial_stop,
   output logic detect_trip_select,
   output logic warning_trip_select,
   output logic powerdown_enable,
   output logic powerdown_type_select,
   output logic irq,
   // AXI4-Lite write address and data.
   input wire logic [psc_pkg::PSC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [psc_pkg::PSC_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [psc_pkg::PSC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [psc_pkg::PSC_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int AW = psc_pkg::PSC_ADDR_W;
   localparam int DW = psc_pkg::PSC_DATA_W;
   localparam int IW = psc_pkg::PSC_IRQ_W;

   // Bus channel state.
   logic aw_got_ff;
   logic w_got_ff;
   logic [AW-1:0] awaddr_ff;
   logic [7:0] wbyte_ff;
   logic wlane_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic awready_ff;
   logic wready_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [DW-1:0] rdata_ff;
   logic [1:0] rresp_ff;

   // Register state.
   logic detect_trip_ff;
   logic warn_trip_ff;
   logic pd_enable_ff;
   logic pd_type_ff;
   logic locked_ff;
   logic [IW-1:0] irq_mask_ff;
   logic irq_ff;
   logic warn_prev_ff;

   // Internal wires.
   logic warn_sync;
   logic warn_flag;
   logic nxt_warn_flag;
   logic ppd_flag;
   logic nxt_ppd_flag;
   logic [IW-1:0] irq_status;
   logic [IW-1:0] nxt_irq_status;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_mask;
   logic wr_hit;
   logic rd_ctrl;
   logic rd_status;
   logic rd_mask;
   logic rd_hit;
   logic warn_ack;
   logic ppd_ack;
   logic warn_rise;
   logic [IW-1:0] irq_set;
   logic [IW-1:0] irq_clr;
   logic [7:0] ctrl_view;
   logic [DW-1:0] rd_word;
   logic nxt_aw_got;
   logic nxt_w_got;
   logic nxt_bvalid;
   logic nxt_rvalid;
   logic [IW-1:0] nxt_irq_mask;

   // The comparator output is asynchronous to sys_clk.
   psc_sync #(.WIDTH(1)) u_warn_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(low_supply_warning),
      .sync_out(warn_sync)
   );

   // Channel handshakes and write execution once both halves are held.
   assign aw_hs = s_axi_awvalid && awready_ff;
   assign w_hs = s_axi_wvalid && wready_ff;
   assign ar_hs = s_axi_arvalid && arready_ff;
   assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

   // Address decode; the low two address bits are ignored.
   assign wr_ctrl = wr_fire && wlane_ff && ({awaddr_ff[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_CTRL);
   assign wr_mask = wr_fire && wlane_ff
                    && ({awaddr_ff[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_IRQ_MASK);
   assign wr_hit = ({awaddr_ff[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_CTRL)
                   || ({awaddr_ff[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_IRQ_STATUS)
                   || ({awaddr_ff[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_IRQ_MASK);
   assign rd_ctrl = ({s_axi_araddr[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_CTRL);
   assign rd_status = ({s_axi_araddr[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_IRQ_STATUS);
   assign rd_mask = ({s_axi_araddr[AW-1:2], 2'b00} == psc_pkg::PSC_OFF_IRQ_MASK);
   assign rd_hit = rd_ctrl || rd_status || rd_mask;

   // Acknowledges are pure write strobes and never stored.
   assign warn_ack = wr_ctrl && wbyte_ff[psc_pkg::PSC_BIT_WARN_ACK];
   assign ppd_ack = wr_ctrl && wbyte_ff[psc_pkg::PSC_BIT_PPD_ACK];

   // Warning flag: the live level keeps it set, so an ack during a warning is void.
   psc_sticky #(.WIDTH(1)) u_warn_flag (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(warn_sync),
      .clr_in(warn_ack && !warn_sync),
      .flag_out(warn_flag),
      .nxt_flag_out(nxt_warn_flag)
   );

   // Partial power-down recovery flag.
   psc_sticky #(.WIDTH(1)) u_ppd_flag (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(wake_from_partial_stop),
      .clr_in(ppd_ack),
      .flag_out(ppd_flag),
      .nxt_flag_out(nxt_ppd_flag)
   );

   // Interrupt events; a status read clears them, a fresh event still wins.
   assign warn_rise = warn_sync && !warn_prev_ff;
   assign irq_set[psc_pkg::PSC_IRQ_WARN] = warn_rise;
   assign irq_set[psc_pkg::PSC_IRQ_PPD_WAKE] = wake_from_partial_stop;
   assign irq_clr = (ar_hs && rd_status) ? {IW{1'b1}} : {IW{1'b0}};

   psc_sticky #(.WIDTH(IW)) u_irq_status (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_in(irq_set),
      .clr_in(irq_clr),
      .flag_out(irq_status),
      .nxt_flag_out(nxt_irq_status)
   );

   // Read view of the control register; ack positions are hard zero.
   assign ctrl_view = {warn_flag, 1'b0, detect_trip_ff, warn_trip_ff,
                       ppd_flag, 1'b0, pd_enable_ff, pd_type_ff};
   assign rd_word = rd_ctrl ? {{(DW-8){1'b0}}, ctrl_view}
                  : rd_status ? {{(DW-IW){1'b0}}, irq_status}
                  : rd_mask ? {{(DW-IW){1'b0}}, irq_mask_ff}
                  : {DW{1'b0}};

   // Next channel state; readies come from flops so they follow these terms.
   assign nxt_aw_got = (aw_got_ff || aw_hs) && !wr_fire;
   assign nxt_w_got = (w_got_ff || w_hs) && !wr_fire;
   assign nxt_bvalid = wr_fire || (bvalid_ff && !s_axi_bready);
   assign nxt_rvalid = ar_hs || (rvalid_ff && !s_axi_rready);
   assign nxt_irq_mask = wr_mask ? wbyte_ff[IW-1:0] : irq_mask_ff;

   // Write channel capture and response.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         wbyte_ff <= 8'h00;
         wlane_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= psc_pkg::PSC_RESP_OKAY;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
      end
      else
      begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         if (aw_hs)
            awaddr_ff <= s_axi_awaddr;
         if (w_hs)
         begin
            wbyte_ff <= s_axi_wdata[7:0];
            wlane_ff <= s_axi_wstrb[0];
         end
         bvalid_ff <= nxt_bvalid;
         if (wr_fire)
            bresp_ff <= wr_hit ? psc_pkg::PSC_RESP_OKAY : psc_pkg::PSC_RESP_SLVERR;
         awready_ff <= !nxt_aw_got && !nxt_bvalid;
         wready_ff <= !nxt_w_got && !nxt_bvalid;
      end
   end

   // Read channel; one read at a time, data captured at the address handshake.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= psc_pkg::PSC_RESP_OKAY;
      end
      else
      begin
         arready_ff <= !nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
         if (ar_hs)
         begin
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? psc_pkg::PSC_RESP_OKAY : psc_pkg::PSC_RESP_SLVERR;
         end
      end
   end

   // Trip selects survive any reset but power-on, so they hold through rst_n.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         if (reset_is_por)
         begin
            detect_trip_ff <= psc_pkg::PSC_BIT_RESET;
            warn_trip_ff <= psc_pkg::PSC_BIT_RESET;
         end
      end
      else if (wr_ctrl)
      begin
         detect_trip_ff <= wbyte_ff[psc_pkg::PSC_BIT_DETECT_TRIP];
         warn_trip_ff <= wbyte_ff[psc_pkg::PSC_BIT_WARN_TRIP];
      end
   end

   // Write-once power-down controls: the first control write locks them.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pd_enable_ff <= psc_pkg::PSC_BIT_RESET;
         pd_type_ff <= psc_pkg::PSC_BIT_RESET;
         locked_ff <= 1'b0;
      end
      else if (wr_ctrl && !locked_ff)
      begin
         pd_enable_ff <= wbyte_ff[psc_pkg::PSC_BIT_PD_ENABLE];
         pd_type_ff <= wbyte_ff[psc_pkg::PSC_BIT_PD_TYPE];
         locked_ff <= 1'b1;
      end
   end

   // Mask and interrupt line; the line is built from next values so it is not late.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         irq_mask_ff <= psc_pkg::PSC_IRQ_RESET;
         irq_ff <= 1'b0;
         warn_prev_ff <= 1'b0;
      end
      else
      begin
         irq_mask_ff <= nxt_irq_mask;
         irq_ff <= |(nxt_irq_status & nxt_irq_mask);
         warn_prev_ff <= warn_sync;
      end
   end

   // Output drive, all from flops.
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign detect_trip_select = detect_trip_ff;
   assign warning_trip_select = warn_trip_ff;
   assign powerdown_enable = pd_enable_ff;
   assign powerdown_type_select = pd_type_ff;
   assign irq = irq_ff;

   // Checks on the register behaviour.
   property p_warn_set;
      @(posedge sys_clk) disable iff (!rst_n)
      warn_sync |=> warn_flag;
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("Warning flag missed a warning.");

   property p_warn_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (warn_flag && !warn_ack) |=> warn_flag;
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("Warning flag dropped unasked.");

   property p_warn_ack;
      @(posedge sys_clk) disable iff (!rst_n)
      warn_ack |=> (warn_flag == $past(warn_sync));
   endproperty
   a_warn_ack: assert property (p_warn_ack) else $error("Warning ack misbehaved.");

   property p_detect_trip;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl |=> detect_trip_select == $past(wbyte_ff[psc_pkg::PSC_BIT_DETECT_TRIP]);
   endproperty
   a_detect_trip: assert property (p_detect_trip) else $error("Detect trip not written.");

   property p_warn_trip;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl |=> warning_trip_select == $past(wbyte_ff[psc_pkg::PSC_BIT_WARN_TRIP]);
   endproperty
   a_warn_trip: assert property (p_warn_trip) else $error("Warning trip not written.");

   property p_trip_keep;
      @(posedge sys_clk)
      (!rst_n && !reset_is_por) |=> $stable(detect_trip_select) && $stable(warning_trip_select);
   endproperty
   a_trip_keep: assert property (p_trip_keep) else $error("Trip select lost on reset.");

   property p_por_clear;
      @(posedge sys_clk)
      (!rst_n && reset_is_por) |=> !detect_trip_select && !warning_trip_select
                                   && !powerdown_enable && !irq;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("Power-on reset left a bit set.");

   property p_ppd_set;
      @(posedge sys_clk) disable iff (!rst_n)
      wake_from_partial_stop |=> ppd_flag ##0 irq_status[psc_pkg::PSC_IRQ_PPD_WAKE];
   endproperty
   a_ppd_set: assert property (p_ppd_set) else $error("Wake flag not set.");

   property p_ppd_ack;
      @(posedge sys_clk) disable iff (!rst_n)
      (ppd_ack && !wake_from_partial_stop) |=> !ppd_flag;
   endproperty
   a_ppd_ack: assert property (p_ppd_ack) else $error("Wake flag not cleared.");

   property p_once;
      @(posedge sys_clk) disable iff (!rst_n)
      (locked_ff && wr_ctrl) |=> $stable(powerdown_enable) && $stable(powerdown_type_select);
   endproperty
   a_once: assert property (p_once) else $error("Write-once bit changed twice.");

   property p_first;
      @(posedge sys_clk) disable iff (!rst_n)
      (!locked_ff && wr_ctrl) |=> powerdown_enable == $past(wbyte_ff[psc_pkg::PSC_BIT_PD_ENABLE])
         && powerdown_type_select == $past(wbyte_ff[psc_pkg::PSC_BIT_PD_TYPE]) && locked_ff;
   endproperty
   a_first: assert property (p_first) else $error("First write not taken.");

   property p_ack_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      s_axi_rvalid |-> !s_axi_rdata[psc_pkg::PSC_BIT_WARN_ACK]
                       && !s_axi_rdata[psc_pkg::PSC_BIT_PPD_ACK];
   endproperty
   a_ack_zero: assert property (p_ack_zero) else $error("Ack bit read back set.");

   property p_irq_level;
      @(posedge sys_clk) disable iff (!rst_n)
      irq == |(irq_status & irq_mask_ff);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("Interrupt line disagrees.");

   property p_write_resp;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_fire |=> s_axi_bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("Write response missing.");

   // Main scenarios.
   c_warn_ack: cover property (@(posedge sys_clk) disable iff (!rst_n) warn_flag ##1 !warn_flag);
   c_lock_retry: cover property (@(posedge sys_clk) disable iff (!rst_n) locked_ff && wr_ctrl);
   c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
   c_soft_reset: cover property (@(posedge sys_clk) !rst_n && !reset_is_por && detect_trip_ff);

endmodule : psc_top

// ---- dv/psc_tb_top.sv ----
// Purpose: Self-checking bench for the power management status and control block.
// Assumes: AXI4-Lite answers within the bench timeout; the warning passes two flops.
// Notes: Random control writes come from a fixed seed, so every run repeats exactly.
`timescale 1ns/100ps
module psc_tb_top;
   // Clock, reset and pin stimulus.
   logic sys_clk, rst_n, reset_is_por, low_supply_warning, wake_from_partial_stop;
   logic detect_trip_select, warning_trip_select, powerdown_enable, powerdown_type_select, irq;
   // Register bus.
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   // Bookkeeping and the expected register state.
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [1:0] resp;
   logic m_det, m_wtrip, m_pden, m_pdtype, m_lock;
   localparam logic [7:0] A_CTRL = psc_pkg::PSC_OFF_CTRL;
   localparam logic [7:0] A_STAT = psc_pkg::PSC_OFF_IRQ_STATUS;
   localparam logic [7:0] A_MASK = psc_pkg::PSC_OFF_IRQ_MASK;

   psc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .reset_is_por(reset_is_por),
      .low_supply_warning(low_supply_warning), .wake_from_partial_stop(wake_from_partial_stop),
      .detect_trip_select(detect_trip_select), .warning_trip_select(warning_trip_select),
      .powerdown_enable(powerdown_enable), .powerdown_type_select(powerdown_type_select),
      .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   // Free-running 100 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // A hung handshake would stall the run forever, so a cycle ceiling cuts it short.
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_errors++;
         $display("wrong value at %0t: run did not finish in time", $time);
         end_of_test();
      end
   end

   // Expected control word from the model; the acknowledge bits always read zero.
   function automatic logic [31:0] exp_ctrl(input logic w, input logic p);
      return {24'h00_0000, w, 1'b0, m_det, m_wtrip, p, 1'b0, m_pden, m_pdtype};
   endfunction : exp_ctrl

   // Control word that keeps the trip selects and raises the chosen acknowledges.
   function automatic logic [31:0] ack_word(input logic w, input logic p);
      return {24'h00_0000, 1'b0, w, m_det, m_wtrip, 1'b0, p, m_pden, m_pdtype};
   endfunction : ack_word

   // Compare of bus words.
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word

   // Compare of output pins.
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_pin

   // Write with address and data offered together; each drops once taken.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      @(posedge sys_clk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge sys_clk);
         if (!aw_ok && s_axi_awready === 1'b1)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   // Read; data and response are taken at the edge where rvalid is seen.
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Mapped write; the model follows control writes and the pins are checked after.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      axi_write(a, d, s, resp);
      chk_word({30'h0000_0000, resp}, {30'h0000_0000, psc_pkg::PSC_RESP_OKAY}, "bresp");
      if (a == A_CTRL && s[0])
      begin
         m_det = d[5];
         m_wtrip = d[4];
         if (!m_lock)
         begin
            m_pden = d[1];
            m_pdtype = d[0];
         end
         m_lock = 1'b1;
      end
      #1;
      chk_pin({detect_trip_select, warning_trip_select, powerdown_enable, powerdown_type_select},
              {m_det, m_wtrip, m_pden, m_pdtype}, "control pins");
   endtask : wr

   // Mapped read compared with an expected word.
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      axi_read(a, rd, resp);
      chk_word(rd, exp, what);
      chk_word({30'h0000_0000, resp}, {30'h0000_0000, psc_pkg::PSC_RESP_OKAY}, "rresp");
   endtask : reg_chk

   // Reset of either kind; only a power-on reset clears the trip selects.
   task automatic do_reset(input logic por);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      reset_is_por <= por;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      if (por)
      begin
         m_det = 1'b0;
         m_wtrip = 1'b0;
      end
      m_pden = 1'b0;
      m_pdtype = 1'b0;
      m_lock = 1'b0;
      #1;
      chk_pin({detect_trip_select, warning_trip_select, powerdown_enable, powerdown_type_select},
              {m_det, m_wtrip, 2'b00}, "pins after reset");
      chk_pin({3'h0, irq}, 4'h0, "irq after reset");
   endtask : do_reset

   // One-cycle wake pulse from the power controller.
   task automatic pulse_wake;
      @(posedge sys_clk);
      wake_from_partial_stop <= 1'b1;
      @(posedge sys_clk);
      wake_from_partial_stop <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : pulse_wake

   // Verdict, printed from this one place only.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   // Main sequence.
   initial
   begin
      {rst_n, low_supply_warning, wake_from_partial_stop} = 3'h0;
      reset_is_por = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0_0000;
      s_axi_wdata = 32'h0000_0000;
      {m_det, m_wtrip, m_pden, m_pdtype, m_lock} = 5'h00;
      void'($urandom(58597));
      do_reset(1'b1);
      reg_chk(A_CTRL, 32'h0000_0000, "control reset value");
      reg_chk(A_MASK, 32'h0000_0000, "mask reset value");
      reg_chk(A_STAT, 32'h0000_0000, "status reset value");
      $display("test reset values done");
      // The first write locks the power-down bits; random writes then try to move them.
      wr(A_CTRL, 32'hFFFF_FF32, 4'h1);
      for (int i = 0; i < 12; i++)
      begin
         wr(A_CTRL, $urandom, 4'($urandom));
         reg_chk(A_CTRL, exp_ctrl(1'b0, 1'b0), "control readback");
      end
      $display("test control writes done");
      low_supply_warning <= 1'b1;
      repeat (5) @(posedge sys_clk);
      reg_chk(A_CTRL, exp_ctrl(1'b1, 1'b0), "warning set");
      wr(A_CTRL, ack_word(1'b1, 1'b0), 4'h1);
      reg_chk(A_CTRL, exp_ctrl(1'b1, 1'b0), "ack while warning live");
      low_supply_warning <= 1'b0;
      repeat (5) @(posedge sys_clk);
      reg_chk(A_CTRL, exp_ctrl(1'b1, 1'b0), "warning sticky");
      wr(A_CTRL, ack_word(1'b1, 1'b0), 4'h1);
      reg_chk(A_CTRL, exp_ctrl(1'b0, 1'b0), "ack clears warning");
      reg_chk(A_STAT, 32'h0000_0001, "warning event status");
      $display("test warning flag done");
      pulse_wake();
      reg_chk(A_CTRL, exp_ctrl(1'b0, 1'b1), "partial wake flag");
      wr(A_CTRL, ack_word(1'b0, 1'b1), 4'h1);
      reg_chk(A_CTRL, exp_ctrl(1'b0, 1'b0), "partial ack clears");
      reg_chk(A_STAT, 32'h0000_0002, "wake event status");
      reg_chk(A_STAT, 32'h0000_0000, "status cleared by read");
      $display("test partial power-down flag done");
      // Interrupt: masked event stays quiet, unmasking raises it, a status read drops it.
      wr(A_MASK, 32'h0000_0001, 4'hF);
      pulse_wake();
      chk_pin({3'h0, irq}, 4'h0, "masked irq");
      wr(A_MASK, 32'h0000_0003, 4'hF);
      chk_pin({3'h0, irq}, 4'h1, "unmasked irq");
      reg_chk(A_STAT, 32'h0000_0002, "irq status");
      #1;
      chk_pin({3'h0, irq}, 4'h0, "irq after status read");
      axi_write(8'h0C, 32'h0000_00FF, 4'hF, resp);
      chk_word({30'h0000_0000, resp}, {30'h0000_0000, psc_pkg::PSC_RESP_SLVERR}, "unmapped b");
      axi_read(8'h0C, rd, resp);
      chk_word(rd, 32'h0000_0000, "unmapped read data");
      chk_word({30'h0000_0000, resp}, {30'h0000_0000, psc_pkg::PSC_RESP_SLVERR}, "unmapped r");
      $display("test interrupt and decode done");
      // A non-power-on reset keeps the trip selects; a live warning sets the flag again.
      low_supply_warning <= 1'b1;
      do_reset(1'b0);
      repeat (5) @(posedge sys_clk);
      reg_chk(A_CTRL, exp_ctrl(1'b1, 1'b0), "control after other reset");
      wr(A_CTRL, 32'h0000_0003, 4'h1);
      wr(A_CTRL, 32'h0000_0030, 4'h1);
      low_supply_warning <= 1'b0;
      repeat (3) @(posedge sys_clk);
      do_reset(1'b1);
      reg_chk(A_CTRL, 32'h0000_0000, "control after power-on reset");
      $display("test reset kinds done");
      end_of_test();
   end
endmodule : psc_tb_top
